// ### logic/sensor_control_pkg.sv
`default_nettype none
package sensor_control_pkg;
  // ************************************************************
  // Device register offsets
  // ************************************************************
  localparam logic [7:0] FILTER_ADDR = 8'h28; // High-pass and data rate
  localparam logic [7:0] SPR_ADDR = 8'h2C; // Speed, polarity, range
  localparam logic [7:0] PWR_ADDR = 8'h2D; // Power control
  localparam logic [7:0] SELFTEST_ADDR = 8'h2E; // Self-test control
  localparam logic [7:0] SWRESET_ADDR = 8'h2F; // Software reset, write only
  localparam logic [7:0] SHADOW_BASE = 8'h50; // First shadow register
  localparam logic [7:0] SHADOW_LAST = 8'h54; // Last shadow register
  localparam int SHADOW_COUNT = 5; // Number of shadow bytes

  // ************************************************************
  // Reset values, writable masks, codes
  // ************************************************************
  localparam logic [7:0] FILTER_RESET = 8'h00;
  localparam logic [7:0] SPR_RESET = 8'h81;
  localparam logic [7:0] PWR_RESET = 8'h01;
  localparam logic [7:0] SELFTEST_RESET = 8'h00;
  localparam logic [7:0] FILTER_MASK = 8'h7F;
  localparam logic [7:0] SPR_MASK = 8'hC3;
  localparam logic [7:0] PWR_MASK = 8'h07;
  localparam logic [7:0] SELFTEST_MASK = 8'h03;
  localparam logic [7:0] SWRESET_CODE = 8'h52;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int BUS_SPEED_BIT = 7;
  localparam int IRQ_POL_BIT = 6;
  localparam int RANGE_LSB = 0;
  localparam int FORCE_LOW_BIT = 2;
  localparam int TEMP_OFF_BIT = 1;
  localparam int STANDBY_BIT = 0;
  localparam int ST_MODE_BIT = 0;
  localparam int ST_FORCE_BIT = 1;
  localparam int HPF_LSB = 4;

  // ************************************************************
  // Host software registers and operations
  // ************************************************************
  localparam logic [3:0] HOST_ADDR_REG = 4'h0; // Target address
  localparam logic [3:0] HOST_DATA_REG = 4'h1; // Write data
  localparam logic [3:0] HOST_GO_REG = 4'h2; // Write starts an operation
  localparam logic [3:0] HOST_STATUS_REG = 4'h3; // Status flags
  localparam logic [3:0] HOST_RESULT_REG = 4'h4; // Last read data
  localparam logic [3:0] HOST_RETRY_REG = 4'h5; // Resets issued by last verify
  localparam logic [1:0] OP_WRITE = 2'h0;
  localparam logic [1:0] OP_READ = 2'h1;
  localparam logic [1:0] OP_CAPTURE = 2'h2;
  localparam logic [1:0] OP_VERIFY_RESET = 2'h3;
  localparam logic [3:0] LOAD_WAIT_CYCLES = 4'h8; // Wait after software reset
  localparam logic [7:0] RETRY_LIMIT = 8'h10; // Give up after this many resets

  // Device load state machine
  typedef enum logic [0:0] {
    DEV_LOAD = 1'b0,
    DEV_RUN = 1'b1
  } dev_state_type;

  // Host sequencer, Gray along the verify path except SGET to RESET or IDLE
  typedef enum logic [2:0] {
    HOST_IDLE = 3'b000,
    HOST_RESET = 3'b001,
    HOST_WAIT = 3'b011,
    HOST_SREQ = 3'b010,
    HOST_SGET = 3'b110,
    HOST_RGET = 3'b100
  } host_state_type;
endpackage
`default_nettype wire

// ### logic/sensor_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sensor_link_if;
  // Register bus between host and sensor
  logic [7:0] addr; // Register address
  logic [7:0] wdata; // Write data
  logic wr; // One-cycle write strobe
  logic rd; // One-cycle read strobe
  logic [7:0] rdata; // Read data, cycle after rd

  // Sensor side
  modport dev (input addr, input wdata, input wr, input rd, output rdata);
  // Host side
  modport host (output addr, output wdata, output wr, output rd, input rdata);
endinterface
`default_nettype wire

// ### logic/sensor_control_regs.sv
// Summary of operation
// R1: Range register resets 0x81; speed, range fields
// R2: Polarity bit selects interrupt pin active level
// R3: Power control resets in standby
// R4: Force-low bit holds ready pin at 0
// R5: Temperature off by bit or standby
// R6: Standby idles datapaths; clear enters measurement
// R7: Entering standby clears sample buffer pointers
// R8: Host configures only while in standby
// R9: High-pass setting changeable during measurement
// R10: Self-test mode bit, resets to 0
// R11: Self-test force bit, resets to 0
// R12: Writing 0x52 resets like power-on
// R13: After reset, load factory shadow settings
// R14: Host stores shadow bytes after power-up
// R15: Host repeats reset until shadows match; code stops after RETRY_LIMIT resets
// R16: Other reset register values do nothing
`timescale 1ns/1ps
`default_nettype none
module sensor_control_regs (
  // Clock, reset, enable
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Register link
  sensor_link_if.dev link,
  // Factory settings store
  output logic [2:0] nvm_index_o,
  input wire logic [7:0] nvm_data_i,
  // Datapath events
  input wire logic irq_event_one_i,
  input wire logic irq_event_two_i,
  input wire logic data_ready_i,
  // Pins and controls
  output logic irq_pin_one_o,
  output logic irq_pin_two_o,
  output logic ready_output_pin_o,
  output logic bus_speed_select_o,
  output logic [1:0] range_o,
  output logic [2:0] hpf_corner_o,
  output logic low_power_o,
  output logic temp_enable_o,
  output logic accel_enable_o,
  output logic pointer_clear_o,
  output logic selftest_mode_enable_o,
  output logic selftest_force_enable_o,
  output logic shadow_valid_o
);
  // ************************************************************
  // State
  // ************************************************************
  logic [7:0] filter_q, filter_d; // Filter settings
  logic [7:0] spr_q, spr_d; // Speed, polarity, range
  logic [7:0] pwr_q, pwr_d; // Power control
  logic [7:0] st_q, st_d; // Self-test control
  logic soft_q, soft_d; // Software reset pending
  sensor_control_pkg::dev_state_type state_q, state_d; // Load sequencer
  logic [2:0] idx_q, idx_d; // Shadow load index
  logic [sensor_control_pkg::SHADOW_COUNT-1:0][7:0] shadow_q, shadow_d; // Shadow bytes
  logic [7:0] rdata_q, rdata_d; // Read data
  logic irq1_q, irq1_d; // Interrupt pin one
  logic irq2_q, irq2_d; // Interrupt pin two
  logic ready_q, ready_d; // Ready pin
  logic temp_q, temp_d; // Temperature enable
  logic accel_q, accel_d; // Acceleration enable
  logic clear_q, clear_d; // Pointer clear pulse
  logic valid_q, valid_d; // Shadows loaded
  logic [7:0] sidx; // Shadow read offset

  assign sidx = link.addr - sensor_control_pkg::SHADOW_BASE;

  // ************************************************************
  // Next-state logic
  // ************************************************************
  always_comb begin
    filter_d = filter_q;
    spr_d = spr_q;
    pwr_d = pwr_q;
    st_d = st_q;
    soft_d = 1'b0;
    state_d = state_q;
    idx_d = idx_q;
    shadow_d = shadow_q;
    rdata_d = 8'h00;
    clear_d = 1'b0;
    valid_d = valid_q;
    // Read decode, unmapped and write-only read as zero
    if (link.rd) begin
      if (link.addr == sensor_control_pkg::FILTER_ADDR) begin
        rdata_d = filter_q;
      end else if (link.addr == sensor_control_pkg::SPR_ADDR) begin
        rdata_d = spr_q;
      end else if (link.addr == sensor_control_pkg::PWR_ADDR) begin
        rdata_d = pwr_q;
      end else if (link.addr == sensor_control_pkg::SELFTEST_ADDR) begin
        rdata_d = st_q;
      end else if (link.addr >= sensor_control_pkg::SHADOW_BASE &&
                   link.addr <= sensor_control_pkg::SHADOW_LAST) begin
        rdata_d = shadow_q[sidx[2:0]];
      end
    end
    // Write decode, reserved bits stay zero
    if (link.wr) begin
      case (link.addr)
        sensor_control_pkg::FILTER_ADDR: begin
          filter_d = link.wdata & sensor_control_pkg::FILTER_MASK; // R9
        end
        sensor_control_pkg::SPR_ADDR: begin
          spr_d = link.wdata & sensor_control_pkg::SPR_MASK; // R1
        end
        sensor_control_pkg::PWR_ADDR: begin
          pwr_d = link.wdata & sensor_control_pkg::PWR_MASK;
        end
        sensor_control_pkg::SELFTEST_ADDR: begin
          st_d = link.wdata & sensor_control_pkg::SELFTEST_MASK; // R10
        end
        sensor_control_pkg::SWRESET_ADDR: begin
          // Only the code arms a reset; other values ignored
          soft_d = (link.wdata == sensor_control_pkg::SWRESET_CODE); // R12 R16
        end
        default: begin
        end
      endcase
    end
    // Rising standby clears buffer pointers
    if (pwr_d[sensor_control_pkg::STANDBY_BIT] &&
        !pwr_q[sensor_control_pkg::STANDBY_BIT]) begin
      clear_d = 1'b1; // R7
    end
    // Factory load into shadow bytes, one per cycle
    case (state_q)
      sensor_control_pkg::DEV_LOAD: begin
        shadow_d[idx_q] = nvm_data_i; // R13
        if (idx_q == 3'(sensor_control_pkg::SHADOW_COUNT - 1)) begin
          state_d = sensor_control_pkg::DEV_RUN;
          valid_d = 1'b1;
          idx_d = 3'h0;
        end else begin
          idx_d = idx_q + 3'h1;
        end
      end
      sensor_control_pkg::DEV_RUN: begin
        idx_d = 3'h0;
      end
      default: begin
        state_d = sensor_control_pkg::DEV_LOAD;
        idx_d = 3'h0;
      end
    endcase
    // Software reset acts like power-on, then reloads
    if (soft_q) begin
      filter_d = sensor_control_pkg::FILTER_RESET; // R12
      spr_d = sensor_control_pkg::SPR_RESET;
      pwr_d = sensor_control_pkg::PWR_RESET;
      st_d = sensor_control_pkg::SELFTEST_RESET;
      state_d = sensor_control_pkg::DEV_LOAD; // R13
      idx_d = 3'h0;
      shadow_d = '0;
      valid_d = 1'b0;
      clear_d = 1'b1;
    end
  end

  // ************************************************************
  // Pin and control outputs
  // ************************************************************
  always_comb begin
    // Active high when polarity set, else inverted
    irq1_d = spr_q[sensor_control_pkg::IRQ_POL_BIT] ? irq_event_one_i : !irq_event_one_i; // R2
    irq2_d = spr_q[sensor_control_pkg::IRQ_POL_BIT] ? irq_event_two_i : !irq_event_two_i; // R2
    // Force-low overrides ready indication
    ready_d = data_ready_i && !pwr_q[sensor_control_pkg::FORCE_LOW_BIT]; // R4
    // Temperature off by bit or by standby
    temp_d = !pwr_q[sensor_control_pkg::TEMP_OFF_BIT] &&
             !pwr_q[sensor_control_pkg::STANDBY_BIT]; // R5
    // Acceleration runs only in measurement
    accel_d = !pwr_q[sensor_control_pkg::STANDBY_BIT]; // R6
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      filter_q <= sensor_control_pkg::FILTER_RESET;
      spr_q <= sensor_control_pkg::SPR_RESET; // R1
      pwr_q <= sensor_control_pkg::PWR_RESET; // R3
      st_q <= sensor_control_pkg::SELFTEST_RESET; // R11
      soft_q <= 1'b0;
      state_q <= sensor_control_pkg::DEV_LOAD;
      idx_q <= 3'h0;
      shadow_q <= '0;
      rdata_q <= 8'h00;
      irq1_q <= 1'b1;
      irq2_q <= 1'b1;
      ready_q <= 1'b0;
      temp_q <= 1'b0;
      accel_q <= 1'b0;
      clear_q <= 1'b1;
      valid_q <= 1'b0;
    end else if (ce_i) begin
      filter_q <= filter_d;
      spr_q <= spr_d;
      pwr_q <= pwr_d;
      st_q <= st_d;
      soft_q <= soft_d;
      state_q <= state_d;
      idx_q <= idx_d;
      shadow_q <= shadow_d;
      rdata_q <= rdata_d;
      irq1_q <= irq1_d;
      irq2_q <= irq2_d;
      ready_q <= ready_d;
      temp_q <= temp_d;
      accel_q <= accel_d;
      clear_q <= clear_d;
      valid_q <= valid_d;
    end
  end

  // ************************************************************
  // Output wiring, all from flops
  // ************************************************************
  assign link.rdata = rdata_q;
  assign nvm_index_o = idx_q;
  assign irq_pin_one_o = irq1_q;
  assign irq_pin_two_o = irq2_q;
  assign ready_output_pin_o = ready_q;
  assign bus_speed_select_o = spr_q[sensor_control_pkg::BUS_SPEED_BIT]; // R1
  assign range_o = spr_q[sensor_control_pkg::RANGE_LSB +: 2];
  assign hpf_corner_o = filter_q[sensor_control_pkg::HPF_LSB +: 3];
  assign low_power_o = pwr_q[sensor_control_pkg::STANDBY_BIT]; // R6
  assign temp_enable_o = temp_q;
  assign accel_enable_o = accel_q;
  assign pointer_clear_o = clear_q;
  assign selftest_mode_enable_o = st_q[sensor_control_pkg::ST_MODE_BIT]; // R10
  assign selftest_force_enable_o = st_q[sensor_control_pkg::ST_FORCE_BIT]; // R11
  assign shadow_valid_o = valid_q;
endmodule
`default_nettype wire

// ### logic/sensor_host_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module sensor_host_ctrl (
  // Clock, reset, enable
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Register link
  sensor_link_if.host link,
  // Software port
  input wire logic [3:0] sw_addr_i,
  input wire logic [7:0] sw_wdata_i,
  input wire logic sw_wr_i,
  input wire logic sw_rd_i,
  output logic [7:0] sw_rdata_o,
  output logic busy_o
);
  // ************************************************************
  // State
  // ************************************************************
  sensor_control_pkg::host_state_type state_q, state_d; // Sequencer
  logic [7:0] taddr_q, taddr_d; // Target address
  logic [7:0] tdata_q, tdata_d; // Target write data
  logic [7:0] result_q, result_d; // Last read
  logic [7:0] retry_q, retry_d; // Resets in last verify
  logic [3:0] wait_q, wait_d; // Reload wait counter
  logic [2:0] sidx_q, sidx_d; // Shadow index
  logic capture_q, capture_d; // Shadow pass stores, not compares
  logic captured_q, captured_d; // Stored copy valid
  logic mismatch_q, mismatch_d; // Last verify failed
  logic refused_q, refused_d; // Last write refused
  logic standby_q, standby_d; // Believed device standby
  logic [sensor_control_pkg::SHADOW_COUNT-1:0][7:0] store_q, store_d; // Stored copy
  logic [7:0] laddr_q, laddr_d; // Link address
  logic [7:0] lwdata_q, lwdata_d; // Link write data
  logic lwr_q, lwr_d; // Link write strobe
  logic lrd_q, lrd_d; // Link read strobe
  logic [7:0] rdata_q, rdata_d; // Software read data
  logic busy_q, busy_d; // Busy flag
  logic go; // Operation start
  logic cfg_ok; // Write allowed now

  assign go = sw_wr_i && sw_addr_i == sensor_control_pkg::HOST_GO_REG;
  // Configuration only in standby, except filter, power, reset
  assign cfg_ok = standby_q || taddr_q == sensor_control_pkg::FILTER_ADDR ||
                  taddr_q == sensor_control_pkg::PWR_ADDR ||
                  taddr_q == sensor_control_pkg::SWRESET_ADDR; // R8 R9

  // ************************************************************
  // Next-state logic
  // ************************************************************
  always_comb begin
    state_d = state_q;
    taddr_d = taddr_q;
    tdata_d = tdata_q;
    result_d = result_q;
    retry_d = retry_q;
    wait_d = wait_q;
    sidx_d = sidx_q;
    capture_d = capture_q;
    captured_d = captured_q;
    mismatch_d = mismatch_q;
    refused_d = refused_q;
    standby_d = standby_q;
    store_d = store_q;
    laddr_d = laddr_q;
    lwdata_d = lwdata_q;
    lwr_d = 1'b0;
    lrd_d = 1'b0;
    rdata_d = 8'h00;
    // Software register writes
    if (sw_wr_i && sw_addr_i == sensor_control_pkg::HOST_ADDR_REG) begin
      taddr_d = sw_wdata_i;
    end
    if (sw_wr_i && sw_addr_i == sensor_control_pkg::HOST_DATA_REG) begin
      tdata_d = sw_wdata_i;
    end
    // Software register reads
    if (sw_rd_i) begin
      case (sw_addr_i)
        sensor_control_pkg::HOST_ADDR_REG: rdata_d = taddr_q;
        sensor_control_pkg::HOST_DATA_REG: rdata_d = tdata_q;
        sensor_control_pkg::HOST_STATUS_REG: begin
          rdata_d = {3'h0, standby_q, captured_q, mismatch_q, refused_q, busy_q};
        end
        sensor_control_pkg::HOST_RESULT_REG: rdata_d = result_q;
        sensor_control_pkg::HOST_RETRY_REG: rdata_d = retry_q;
        default: rdata_d = 8'h00;
      endcase
    end
    // Sequencer
    case (state_q)
      sensor_control_pkg::HOST_IDLE: begin
        if (go) begin
          refused_d = 1'b0;
          laddr_d = taddr_q;
          lwdata_d = tdata_q;
          case (sw_wdata_i[1:0])
            sensor_control_pkg::OP_WRITE: begin
              if (cfg_ok) begin
                lwr_d = 1'b1;
                if (taddr_q == sensor_control_pkg::PWR_ADDR) begin
                  standby_d = tdata_q[sensor_control_pkg::STANDBY_BIT];
                end
              end else begin
                refused_d = 1'b1; // R8
              end
            end
            sensor_control_pkg::OP_READ: begin
              lrd_d = 1'b1;
              state_d = sensor_control_pkg::HOST_RGET;
            end
            sensor_control_pkg::OP_CAPTURE: begin
              capture_d = 1'b1; // R14
              sidx_d = 3'h0;
              state_d = sensor_control_pkg::HOST_SREQ;
            end
            default: begin
              capture_d = 1'b0;
              retry_d = 8'h00;
              state_d = sensor_control_pkg::HOST_RESET;
            end
          endcase
        end
      end
      sensor_control_pkg::HOST_RGET: begin
        // Strobe still out: the answer stands next cycle
        if (!lrd_q) begin
          result_d = link.rdata;
          state_d = sensor_control_pkg::HOST_IDLE;
        end
      end
      sensor_control_pkg::HOST_RESET: begin
        // Issue the reset code and note device back in standby
        laddr_d = sensor_control_pkg::SWRESET_ADDR;
        lwdata_d = sensor_control_pkg::SWRESET_CODE;
        lwr_d = 1'b1;
        standby_d = 1'b1;
        retry_d = retry_q + 8'h01;
        mismatch_d = 1'b0;
        wait_d = sensor_control_pkg::LOAD_WAIT_CYCLES;
        sidx_d = 3'h0;
        state_d = sensor_control_pkg::HOST_WAIT;
      end
      sensor_control_pkg::HOST_WAIT: begin
        // Let the device finish reloading shadows
        wait_d = wait_q - 4'h1;
        if (wait_q == 4'h1) begin
          state_d = sensor_control_pkg::HOST_SREQ;
        end
      end
      sensor_control_pkg::HOST_SREQ: begin
        // Stay while the strobe is out so SGET sees the answer
        if (lrd_q) begin
          state_d = sensor_control_pkg::HOST_SGET;
        end else begin
          laddr_d = sensor_control_pkg::SHADOW_BASE + {5'h00, sidx_q};
          lrd_d = 1'b1;
        end
      end
      sensor_control_pkg::HOST_SGET: begin
        if (capture_q) begin
          store_d[sidx_q] = link.rdata; // R14
        end else if (!captured_q || link.rdata != store_q[sidx_q]) begin
          mismatch_d = 1'b1; // R15
        end
        if (sidx_q == 3'(sensor_control_pkg::SHADOW_COUNT - 1)) begin
          if (capture_q) begin
            captured_d = 1'b1;
            state_d = sensor_control_pkg::HOST_IDLE;
          end else if ((mismatch_d && captured_q) && retry_q < sensor_control_pkg::RETRY_LIMIT) begin
            state_d = sensor_control_pkg::HOST_RESET; // R15
          end else begin
            state_d = sensor_control_pkg::HOST_IDLE;
          end
        end else begin
          sidx_d = sidx_q + 3'h1;
          state_d = sensor_control_pkg::HOST_SREQ;
        end
      end
      default: begin
        state_d = sensor_control_pkg::HOST_IDLE;
      end
    endcase
    busy_d = state_d != sensor_control_pkg::HOST_IDLE;
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= sensor_control_pkg::HOST_IDLE;
      taddr_q <= 8'h00;
      tdata_q <= 8'h00;
      result_q <= 8'h00;
      retry_q <= 8'h00;
      wait_q <= 4'h0;
      sidx_q <= 3'h0;
      capture_q <= 1'b0;
      captured_q <= 1'b0;
      mismatch_q <= 1'b0;
      refused_q <= 1'b0;
      standby_q <= 1'b1;
      store_q <= '0;
      laddr_q <= 8'h00;
      lwdata_q <= 8'h00;
      lwr_q <= 1'b0;
      lrd_q <= 1'b0;
      rdata_q <= 8'h00;
      busy_q <= 1'b0;
    end else if (ce_i) begin
      state_q <= state_d;
      taddr_q <= taddr_d;
      tdata_q <= tdata_d;
      result_q <= result_d;
      retry_q <= retry_d;
      wait_q <= wait_d;
      sidx_q <= sidx_d;
      capture_q <= capture_d;
      captured_q <= captured_d;
      mismatch_q <= mismatch_d;
      refused_q <= refused_d;
      standby_q <= standby_d;
      store_q <= store_d;
      laddr_q <= laddr_d;
      lwdata_q <= lwdata_d;
      lwr_q <= lwr_d;
      lrd_q <= lrd_d;
      rdata_q <= rdata_d;
      busy_q <= busy_d;
    end
  end

  // ************************************************************
  // Output wiring, all from flops
  // ************************************************************
  assign link.addr = laddr_q;
  assign link.wdata = lwdata_q;
  assign link.wr = lwr_q;
  assign link.rd = lrd_q;
  assign sw_rdata_o = rdata_q;
  assign busy_o = busy_q;
endmodule
`default_nettype wire

// ### verif/sensor_link_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module sensor_link_monitor (
  // Clock, reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Register link
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_i,
  // Device controls
  input wire logic low_power_i,
  input wire logic temp_enable_i,
  input wire logic accel_enable_i,
  input wire logic pointer_clear_i,
  input wire logic [1:0] range_i,
  input wire logic selftest_mode_enable_i
);
  default clocking dc @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // Reset code written
  sequence swr_req;
    wr_i && addr_i == 8'h2F && wdata_i == sensor_control_pkg::SWRESET_CODE;
  endsequence
  a_range_write: assert property (wr_i && addr_i == 8'h2C |=>
    {6'h00, range_i} == ($past(wdata_i) & 8'h03)) else $error("range not taken");
  a_selftest_write: assert property (wr_i && addr_i == 8'h2E |=>
    {7'h00, selftest_mode_enable_i} == ($past(wdata_i) & 8'h01))
    else $error("self-test bit not taken");
  a_standby_idle: assert property (low_power_i |=> !accel_enable_i && !temp_enable_i)
    else $error("datapath runs in standby");
  a_measure_enter: assert property (!low_power_i |=> accel_enable_i)
    else $error("no measurement");
  a_temp_cause: assert property (temp_enable_i |-> !$past(low_power_i))
    else $error("temperature on in standby");
  a_standby_clear: assert property ($rose(low_power_i) |-> ##[0:2] pointer_clear_i)
    else $error("pointers kept");
  a_swreset_standby: assert property (swr_req |-> ##[1:3] low_power_i)
    else $error("soft reset ignored");
  a_swreset_reload: assert property (swr_req |-> ##[1:3] pointer_clear_i)
    else $error("no reload");
  a_read_power: assert property (rd_i && addr_i == 8'h2D |=>
    rdata_i[0] == $past(low_power_i)) else $error("power read wrong");
endmodule
`default_nettype wire

// ### verif/sensor_control_registers_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin err_count++; \
  $display("FAIL %0t got %h exp %h", $time, a, e); end end
module sensor_control_registers_tb_top;
  logic clock_i = 0;
  logic rst_i = 1;
  logic [3:0] sw_addr = 0;
  logic [7:0] sw_wdata = 0;
  logic sw_wr = 0, sw_rd = 0, bad = 0, ev1 = 0, raw_rdy = 0;
  logic [7:0] sw_rdata, d;
  logic [2:0] nvm_index, hpf;
  logic [1:0] rng;
  logic busy, irq1, irq2, ready, speed, lowp, tempe, acce, pclr, stm, stf, valid;
  logic [7:0] exp_rst [5] = '{8'h81, 8'h01, 8'h00, 8'h00, 8'h00};
  int err_count = 0;
  int check_count = 0;
  always #20 clock_i = ~clock_i;
  // Corrupt factory data until one reload completes
  always @(posedge valid) bad <= 0;
  sensor_link_if link_bus ();
  sensor_control_regs i_sensor_control_regs (.clock_i(clock_i), .rst_i(rst_i), .ce_i(1'b1),
    .link(link_bus.dev), .nvm_index_o(nvm_index), .nvm_data_i({5'h14, nvm_index} ^ {8{bad}}),
    .irq_event_one_i(ev1), .irq_event_two_i(~ev1), .data_ready_i(raw_rdy),
    .irq_pin_one_o(irq1), .irq_pin_two_o(irq2), .ready_output_pin_o(ready),
    .bus_speed_select_o(speed), .range_o(rng), .hpf_corner_o(hpf), .low_power_o(lowp),
    .temp_enable_o(tempe), .accel_enable_o(acce), .pointer_clear_o(pclr),
    .selftest_mode_enable_o(stm), .selftest_force_enable_o(stf), .shadow_valid_o(valid));
  sensor_host_ctrl i_sensor_host_ctrl (.clock_i(clock_i), .rst_i(rst_i), .ce_i(1'b1),
    .link(link_bus.host), .sw_addr_i(sw_addr), .sw_wdata_i(sw_wdata), .sw_wr_i(sw_wr),
    .sw_rd_i(sw_rd), .sw_rdata_o(sw_rdata), .busy_o(busy));
  sensor_link_monitor i_sensor_link_monitor (.clock_i(clock_i), .rst_i(rst_i),
    .addr_i(link_bus.addr), .wdata_i(link_bus.wdata), .wr_i(link_bus.wr), .rd_i(link_bus.rd),
    .rdata_i(link_bus.rdata), .low_power_i(lowp), .temp_enable_i(tempe),
    .accel_enable_i(acce), .pointer_clear_i(pclr), .range_i(rng),
    .selftest_mode_enable_i(stm));
  // Software port write and read
  task automatic sw_w(input logic [3:0] a, input logic [7:0] v);
    @(posedge clock_i);
    sw_addr <= a;
    sw_wdata <= v;
    sw_wr <= 1;
    @(posedge clock_i);
    sw_wr <= 0;
  endtask
  task automatic sw_r(input logic [3:0] a);
    @(posedge clock_i);
    sw_addr <= a;
    sw_rd <= 1;
    @(posedge clock_i);
    sw_rd <= 0;
    #1 d = sw_rdata;
  endtask
  // One device operation, waits for the host to finish
  task automatic op(input logic [7:0] a, input logic [7:0] v, input logic [1:0] o);
    sw_w(4'h0, a);
    sw_w(4'h1, v);
    sw_w(4'h2, {6'h00, o});
    repeat (2) @(posedge clock_i);
    while (busy !== 1'b0) @(posedge clock_i);
    #1;
  endtask
  task automatic dev_rd(input logic [7:0] a);
    op(a, 8'h00, sensor_control_pkg::OP_READ);
    sw_r(sensor_control_pkg::HOST_RESULT_REG);
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock_i);
    err_count++;
    final_report();
  end
  initial begin
    repeat (10) @(posedge clock_i);
    rst_i <= 0;
    repeat (8) @(posedge clock_i);
    #1 `CHK({lowp, tempe, acce, speed, rng, irq1, ready}, 8'h96)
    for (int i = 0; i < 5; i++) begin
      dev_rd(8'h2C + i[7:0]);
      `CHK(d, exp_rst[i])
    end
    dev_rd(8'h51);
    `CHK(d, 8'hA1)
    $display("test reset values done");
    for (int r = 1; r < 4; r++) begin
      op(8'h2C, 8'h40 | r[7:0], sensor_control_pkg::OP_WRITE);
      `CHK({speed, irq1, rng}, {2'b00, r[1:0]})
    end
    @(posedge clock_i);
    ev1 <= 1;
    raw_rdy <= 1;
    repeat (2) @(posedge clock_i);
    #1 `CHK({irq1, irq2, ready}, 3'b101)
    op(8'h2E, 8'h02, sensor_control_pkg::OP_WRITE);
    `CHK({stm, stf}, 2'b01)
    op(8'h2E, 8'h01, sensor_control_pkg::OP_WRITE);
    `CHK({stm, stf}, 2'b10)
    $display("test configuration done");
    op(8'h2D, 8'h05, sensor_control_pkg::OP_WRITE);
    `CHK({ready, lowp}, 2'b01)
    op(8'h2D, 8'h00, sensor_control_pkg::OP_WRITE);
    `CHK({ready, lowp, tempe, acce}, 4'b1011)
    op(8'h2D, 8'h02, sensor_control_pkg::OP_WRITE);
    `CHK({tempe, acce}, 2'b01)
    op(8'h2C, 8'h83, sensor_control_pkg::OP_WRITE);
    dev_rd(8'h2C);
    `CHK(d, 8'h43)
    op(8'h28, 8'h30, sensor_control_pkg::OP_WRITE);
    `CHK(hpf, 3'h3)
    op(8'h2D, 8'h01, sensor_control_pkg::OP_WRITE);
    `CHK({lowp, acce}, 2'b10)
    $display("test power modes done");
    op(8'h2F, 8'h51, sensor_control_pkg::OP_WRITE);
    dev_rd(8'h2C);
    `CHK(d, 8'h43)
    op(8'h00, 8'h00, sensor_control_pkg::OP_CAPTURE);
    @(posedge clock_i);
    bad <= 1;
    op(8'h00, 8'h00, sensor_control_pkg::OP_VERIFY_RESET);
    sw_r(sensor_control_pkg::HOST_RETRY_REG);
    `CHK(d, 8'h02)
    sw_r(sensor_control_pkg::HOST_STATUS_REG);
    `CHK(d[2], 1'b0)
    dev_rd(8'h2C);
    `CHK({d, valid}, {8'h81, 1'b1})
    $display("test soft reset done");
    final_report();
  end
endmodule
`default_nettype wire
